//--- inc/gpfoc_pkg.sv
// Package for the pin-function and enable-output configuration block.
// Assumes a single 10 MHz core clock and a plain byte register port.
package gpfoc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TRIM_NORM_BASE   = 8'h00;
  localparam logic [7:0] TRIM_NORM_LAST   = 8'h0b;
  localparam logic [7:0] DAC_EN_LO        = 8'h1c;
  localparam logic [7:0] DAC_EN_HI        = 8'h1d;
  localparam logic [7:0] PIN_FUNC_A       = 8'h1d;
  localparam logic [7:0] PIN_FUNC_B       = 8'h1e;
  localparam logic [7:0] ENOUT_CFG_FIRST  = 8'h1f;
  localparam logic [7:0] ENOUT_CFG_SECOND = 8'h20;
  localparam logic [7:0] ENOUT_CFG_THIRD  = 8'h21;
  localparam logic [7:0] HOLD_CTRL        = 8'h4d;
  localparam logic [7:0] TRIM_UP_BASE     = 8'h66;
  localparam logic [7:0] TRIM_UP_LAST     = 8'h71;
  localparam logic [7:0] TRIM_DN_BASE     = 8'h72;
  localparam logic [7:0] TRIM_DN_LAST     = 8'h7d;
  localparam logic [7:0] PAGE_CTRL        = 8'h80;
  localparam logic [7:0] RST_TMO_REG      = 8'h81;
  localparam logic [7:0] STATUS_REG       = 8'h82;

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int          NUM_TRIM     = 12;
  localparam int          NUM_ENOUT    = 9;
  localparam int          HOLD_BIT     = 1;
  localparam int          PAGE_BIT     = 0;
  localparam int          DOG_A_BIT    = 7;
  localparam logic [2:0]  DOG_OUT_CODE = 3'h6;
  localparam logic [2:0]  KICK_CODE    = 3'h7;
  localparam logic [2:0]  CFG_TRACK    = 3'h4;
  localparam logic [2:0]  CFG_CPUMP    = 3'h5;
  localparam logic [7:0]  RST_TMO_RST  = 8'h10;
  localparam logic [15:0] RST_TMO_UNIT = 16'h0064;

  typedef enum logic [2:0] {
    DRV_OD_LO,
    DRV_OD_HI,
    DRV_PP_LO,
    DRV_PP_HI,
    DRV_TRACK,
    DRV_CPUMP,
    DRV_RSVD
  } gpfoc_drv_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } gpfoc_bus_t;

endpackage

//--- src/gpfoc_top.sv
// Pin-function routing, trim bank select, supervision hold and enable-output decode.
// Assumes strobes from logic on core_clk; pins arrive asynchronous and are synchronised.
//
// Operation
// - Raise high, lower low: drive trim from lower bank, switches closed.
// - Raise low, lower high: drive trim from raise bank, switches closed.
// - Equal selects: normal bank, switches follow DAC-enable bits.
// - DAC-enable registers reachable only on the extended page.
// - Hold active when hold pin low or software hold bit set.
// - Hold freezes both alarms, any-alarm and reset outputs.
// - Hold ignores rail violations and blocks fault logging.
// - Manual reset low asserts reset while it stays low.
// - After manual reset release, reset stays for the timeout period.
// - Pattern 110 on pin-function bits routes the dog timeout output.
// - Pattern 111 on bits 6 to 4 routes the kick input.
// - Dog timeout output is open-drain active low.
// - Outputs 1 to 4 decode open-drain, push-pull, tracking, charge-pump.
// - Outputs 5 and 6 treat tracking code as reserved.
// - Two-bit fields for outputs 7 up decode drive and polarity.
// - Outputs 1 to 3 field layout in first config register, output 3 top bit in bit 0 of second.
// - Outputs 4 to 6 field layout in second and third.
// - Outputs 7 to 9 in third register upper bits.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
module gpfoc_top
  import gpfoc_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 clk_en,
  // Register port.
  input  wire gpfoc_bus_t           bus,
  output logic [7:0]                rdata,
  // Pins.
  input  wire logic                 trim_raise_select,
  input  wire logic                 trim_lower_select,
  input  wire logic                 supervise_hold_n,
  input  wire logic                 manual_rst_n,
  input  wire logic                 kick_pin,
  // Monitoring inputs.
  input  wire logic                 rail_fault_in,
  input  wire logic                 alarm_one_in,
  input  wire logic                 alarm_two_in,
  input  wire logic                 reset_req_in,
  input  wire logic                 dog_expired_in,
  // Outputs.
  output logic [NUM_TRIM-1:0][7:0]  trim_level_out,
  output logic [NUM_TRIM-1:0]       dac_switch_closed,
  output logic                      alarm_out_one,
  output logic                      alarm_out_two,
  output logic                      alarm_any,
  output logic                      reset_out_n,
  output logic                      fault_log_req,
  output logic                      kick_input,
  output logic                      dog_timeout_out,
  output logic                      dog_timeout_oe_n,
  output gpfoc_drv_t [NUM_ENOUT-1:0] enout_drv
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] norm_r [NUM_TRIM];
  logic [7:0] up_r   [NUM_TRIM];
  logic [7:0] dn_r   [NUM_TRIM];
  logic [7:0] dac_en_lo_r;
  logic [7:0] dac_en_hi_r;
  logic [7:0] pin_func_a_r;
  logic [7:0] pin_func_b_r;
  logic [7:0] cfg1_r;
  logic [7:0] cfg2_r;
  logic [7:0] cfg3_r;
  logic [7:0] hold_ctrl_r;
  logic       page_r;
  logic [7:0] rst_tmo_r;

  logic       ext;
  assign ext = page_r;

  // Dual-mapped address: page selects DAC-enable high over pin function A.
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_TRIM; i++)
      begin
        norm_r[i] <= 8'h00;
        up_r[i]   <= 8'h00;
        dn_r[i]   <= 8'h00;
      end
      dac_en_lo_r  <= 8'h00;
      dac_en_hi_r  <= 8'h00;
      pin_func_a_r <= 8'h00;
      pin_func_b_r <= 8'h00;
      cfg1_r       <= 8'h00;
      cfg2_r       <= 8'h00;
      cfg3_r       <= 8'h00;
      hold_ctrl_r  <= 8'h00;
      page_r       <= 1'b0;
      rst_tmo_r    <= RST_TMO_RST;
    end
    else if (clk_en && bus.wr)
    begin
      if (bus.addr <= TRIM_NORM_LAST)
        norm_r[bus.addr[3:0]] <= bus.wdata;
      else if (bus.addr >= TRIM_UP_BASE && bus.addr <= TRIM_UP_LAST)
        up_r[4'(bus.addr - TRIM_UP_BASE)] <= bus.wdata;
      else if (bus.addr >= TRIM_DN_BASE && bus.addr <= TRIM_DN_LAST)
        dn_r[4'(bus.addr - TRIM_DN_BASE)] <= bus.wdata;
      else if (bus.addr == DAC_EN_LO && ext)
        dac_en_lo_r <= bus.wdata;
      else if (bus.addr == DAC_EN_HI && ext)
        dac_en_hi_r <= bus.wdata;
      else if (bus.addr == PIN_FUNC_A && !ext)
        pin_func_a_r <= bus.wdata;
      else if (bus.addr == PIN_FUNC_B && !ext)
        pin_func_b_r <= bus.wdata;
      else if (bus.addr == ENOUT_CFG_FIRST && !ext)
        cfg1_r <= bus.wdata;
      else if (bus.addr == ENOUT_CFG_SECOND && !ext)
        cfg2_r <= bus.wdata;
      else if (bus.addr == ENOUT_CFG_THIRD && !ext)
        cfg3_r <= bus.wdata;
      else if (bus.addr == HOLD_CTRL)
        hold_ctrl_r <= bus.wdata;
      else if (bus.addr == PAGE_CTRL)
        page_r <= bus.wdata[PAGE_BIT];
      else if (bus.addr == RST_TMO_REG)
        rst_tmo_r <= bus.wdata;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] pin_r;
  assign pin_raw = {kick_pin, manual_rst_n, supervise_hold_n,
                    trim_lower_select, trim_raise_select};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r  <= 5'h1f;
      s2_r  <= 5'h1f;
      s3_r  <= 5'h1f;
      pin_r <= 5'h1f;
    end
    else if (clk_en)
    begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NPIN; i++)
        if (s2_r[i] == s3_r[i])
          pin_r[i] <= s3_r[i];
    end
  end

  logic up_s, dn_s, hold_n_s, mr_n_s, kick_s;
  assign {kick_s, mr_n_s, hold_n_s, dn_s, up_s} = pin_r;

  // ****************************************************************
  // Trim bank select
  // ****************************************************************
  logic [15:0] dac_en;
  assign dac_en = {dac_en_hi_r, dac_en_lo_r};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trim_level_out    <= '0;
      dac_switch_closed <= '0;
    end
    else if (clk_en)
    begin
      for (int i = 0; i < NUM_TRIM; i++)
      begin
        if (up_s && !dn_s)
        begin
          trim_level_out[i]    <= dn_r[i];
          dac_switch_closed[i] <= 1'b1;
        end
        else if (!up_s && dn_s)
        begin
          trim_level_out[i]    <= up_r[i];
          dac_switch_closed[i] <= 1'b1;
        end
        else
        begin
          trim_level_out[i]    <= norm_r[i];
          dac_switch_closed[i] <= dac_en[i];
        end
      end
    end
  end

  // ****************************************************************
  // Supervision hold and manual reset
  // ****************************************************************
  logic        hold;
  logic        mr_prev_r;
  logic [15:0] unit_cnt_r;
  logic [7:0]  tmo_cnt_r;
  logic        mr_stretch;
  assign hold = !hold_n_s || hold_ctrl_r[HOLD_BIT];
  assign mr_stretch = (tmo_cnt_r != 8'h00);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mr_prev_r  <= 1'b1;
      unit_cnt_r <= 16'h0000;
      tmo_cnt_r  <= 8'h00;
    end
    else if (clk_en)
    begin
      mr_prev_r <= mr_n_s;
      if (!mr_n_s)
      begin
        tmo_cnt_r  <= 8'h00;
        unit_cnt_r <= 16'h0000;
      end
      else if (!mr_prev_r)
      begin
        tmo_cnt_r  <= rst_tmo_r;
        unit_cnt_r <= 16'h0000;
      end
      else if (mr_stretch)
      begin
        if (unit_cnt_r == RST_TMO_UNIT - 16'h0001)
        begin
          unit_cnt_r <= 16'h0000;
          tmo_cnt_r  <= tmo_cnt_r - 8'h01;
        end
        else
          unit_cnt_r <= unit_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_out_one <= 1'b0;
      alarm_out_two <= 1'b0;
      alarm_any     <= 1'b0;
      reset_out_n   <= 1'b0;
      fault_log_req <= 1'b0;
    end
    else if (clk_en)
    begin
      fault_log_req <= rail_fault_in && !hold;
      if (!hold)
      begin
        alarm_out_one <= alarm_one_in && rail_fault_in;
        alarm_out_two <= alarm_two_in && rail_fault_in;
        alarm_any     <= rail_fault_in;
        reset_out_n   <= !(reset_req_in || !mr_n_s || !mr_prev_r || mr_stretch);
      end
    end
  end

  // ****************************************************************
  // Watchdog pin routing
  // ****************************************************************
  logic dog_sel, kick_sel;
  assign dog_sel  = ({pin_func_b_r[1:0], pin_func_a_r[DOG_A_BIT]} == DOG_OUT_CODE);
  assign kick_sel = (pin_func_a_r[6:4] == KICK_CODE);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      kick_input       <= 1'b0;
      dog_timeout_out  <= 1'b0;
      dog_timeout_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      kick_input       <= kick_sel && kick_s;
      dog_timeout_out  <= 1'b0;
      dog_timeout_oe_n <= !(dog_sel && dog_expired_in);
    end
  end

  // ****************************************************************
  // Enable-output configuration decode
  // ****************************************************************
  logic [NUM_ENOUT-1:0][2:0] fld;
  assign fld[0] = cfg1_r[2:0];
  assign fld[1] = cfg1_r[5:3];
  assign fld[2] = {cfg2_r[0], cfg1_r[7:6]};
  assign fld[3] = cfg2_r[3:1];
  assign fld[4] = cfg2_r[6:4];
  assign fld[5] = {cfg3_r[1:0], cfg2_r[7]};
  assign fld[6] = {1'b0, cfg3_r[3:2]};
  assign fld[7] = {1'b0, cfg3_r[5:4]};
  assign fld[8] = {1'b0, cfg3_r[7:6]};

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      enout_drv <= '{default: DRV_OD_LO};
    else if (clk_en)
    begin
      for (int i = 0; i < NUM_ENOUT; i++)
      begin
        if (fld[i] == CFG_TRACK)
          enout_drv[i] <= (i < 4) ? DRV_TRACK : DRV_RSVD;
        else if (fld[i] == CFG_CPUMP)
          enout_drv[i] <= DRV_CPUMP;
        else if (fld[i][2])
          enout_drv[i] <= DRV_RSVD;
        else
          enout_drv[i] <= gpfoc_drv_t'(fld[i]);
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (clk_en)
    begin
      rdata <= 8'h00;
      if (bus.rd)
      begin
        if (bus.addr <= TRIM_NORM_LAST)
          rdata <= norm_r[bus.addr[3:0]];
        else if (bus.addr >= TRIM_UP_BASE && bus.addr <= TRIM_UP_LAST)
          rdata <= up_r[4'(bus.addr - TRIM_UP_BASE)];
        else if (bus.addr >= TRIM_DN_BASE && bus.addr <= TRIM_DN_LAST)
          rdata <= dn_r[4'(bus.addr - TRIM_DN_BASE)];
        else if (bus.addr == DAC_EN_LO && ext)
          rdata <= dac_en_lo_r;
        else if (bus.addr == DAC_EN_HI && ext)
          rdata <= dac_en_hi_r;
        else if (bus.addr == PIN_FUNC_A && !ext)
          rdata <= pin_func_a_r;
        else if (bus.addr == PIN_FUNC_B && !ext)
          rdata <= pin_func_b_r;
        else if (bus.addr == ENOUT_CFG_FIRST && !ext)
          rdata <= cfg1_r;
        else if (bus.addr == ENOUT_CFG_SECOND && !ext)
          rdata <= cfg2_r;
        else if (bus.addr == ENOUT_CFG_THIRD && !ext)
          rdata <= cfg3_r;
        else if (bus.addr == HOLD_CTRL)
          rdata <= hold_ctrl_r;
        else if (bus.addr == PAGE_CTRL)
          rdata <= {7'h00, page_r};
        else if (bus.addr == RST_TMO_REG)
          rdata <= rst_tmo_r;
        else if (bus.addr == STATUS_REG)
          rdata <= {2'h0, mr_stretch, hold, dn_s, up_s, !reset_out_n, dog_sel};
      end
    end
  end

endmodule

//--- testbench/gpfoc_assertions.sv
// Port checker for the configuration block top.
// Assumes one core_clk domain and a bind to gpfoc_top.
`timescale 1ns/10ps
module gpfoc_chk
  import gpfoc_pkg::*;
(
  // Clock and reset.
  input wire logic                       core_clk,
  input wire logic                       nrst,
  // Watched ports.
  input wire gpfoc_bus_t                 bus,
  input wire logic [7:0]                 rdata,
  input wire logic                       trim_raise_select,
  input wire logic                       trim_lower_select,
  input wire logic                       supervise_hold_n,
  input wire logic                       manual_rst_n,
  input wire logic                       dog_expired_in,
  input wire logic [NUM_TRIM-1:0]        dac_switch_closed,
  input wire logic                       alarm_out_one,
  input wire logic                       alarm_any,
  input wire logic                       reset_out_n,
  input wire logic                       dog_timeout_out,
  input wire logic                       dog_timeout_oe_n,
  input wire gpfoc_drv_t [NUM_ENOUT-1:0] enout_drv
);
  // ****************************************************************
  // Helper state and properties
  // ****************************************************************
  logic page_r;
  logic hold_r;
  logic pwr;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Page and software hold mirror the register writes.
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      page_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (bus.wr && bus.addr == PAGE_CTRL)
      page_r <= bus.wdata[PAGE_BIT];
    else if (bus.wr && bus.addr == HOLD_CTRL)
      hold_r <= bus.wdata[HOLD_BIT];
  assign pwr = bus.wr && !page_r;
  property p_page;
    bus.rd && !page_r && bus.addr == DAC_EN_LO |=> rdata == 8'h00;
  endproperty
  a_page: assert property (p_page) else $error("dac enable seen on primary page");
  property p_cfg1;
    pwr && bus.addr == ENOUT_CFG_FIRST && bus.wdata[2:0] == CFG_CPUMP
      |-> ##2 enout_drv[0] == DRV_CPUMP;
  endproperty
  a_cfg1: assert property (p_cfg1) else $error("output 1 pump code");
  property p_out5;
    pwr && bus.addr == ENOUT_CFG_SECOND && bus.wdata[6:4] == CFG_TRACK
      |-> ##2 enout_drv[4] == DRV_RSVD;
  endproperty
  a_out5: assert property (p_out5) else $error("output 5 tracking");
  property p_out79;
    pwr && bus.addr == ENOUT_CFG_THIRD
      |-> ##2 enout_drv[6] == gpfoc_drv_t'({1'b0, $past(bus.wdata[3:2], 2)})
      && enout_drv[8] == gpfoc_drv_t'({1'b0, $past(bus.wdata[7:6], 2)});
  endproperty
  a_out79: assert property (p_out79) else $error("two bit decode");
  property p_margin;
    (trim_raise_select != trim_lower_select)[*8] |-> &dac_switch_closed;
  endproperty
  a_margin: assert property (p_margin) else $error("switches open in trim");
  property p_hold;
    (!supervise_hold_n)[*8] |=> $stable(alarm_out_one) && $stable(alarm_any)
      && $stable(reset_out_n);
  endproperty
  a_hold: assert property (p_hold) else $error("outputs moved in hold");
  property p_mr;
    (!manual_rst_n && supervise_hold_n && !hold_r)[*8] |-> !reset_out_n;
  endproperty
  a_mr: assert property (p_mr) else $error("manual reset not seen");
  property p_mr_rel;
    $rose(manual_rst_n) && supervise_hold_n && !hold_r |=> (!reset_out_n)[*8];
  endproperty
  a_mr_rel: assert property (p_mr_rel) else $error("reset released early");
  property p_dog;
    (!dog_expired_in)[*2] |=> dog_timeout_oe_n && !dog_timeout_out;
  endproperty
  a_dog: assert property (p_dog) else $error("dog line pulled idle");
  c_cfg: cover property (pwr && bus.addr == ENOUT_CFG_FIRST);
  c_hold: cover property ((!supervise_hold_n)[*8]);
  c_mr: cover property ($rose(manual_rst_n));
endmodule

bind gpfoc_top gpfoc_chk u_chk (.core_clk, .nrst, .bus, .rdata, .trim_raise_select,
  .trim_lower_select, .supervise_hold_n, .manual_rst_n, .dog_expired_in,
  .dac_switch_closed, .alarm_out_one, .alarm_any, .reset_out_n, .dog_timeout_out,
  .dog_timeout_oe_n, .enout_drv);

//--- testbench/gpfoc_partner.sv
// Far side: host hold pin, supply fault level and pulled-up dog line.
// Assumes bench commands change at core_clk rising edges.
`timescale 1ns/10ps
module gpfoc_partner (
  // Clock and bench commands.
  input wire logic  core_clk,
  input wire logic  hold_req,
  input wire logic  rail_bad,
  // Device side.
  input wire logic  dog_oe_n,
  input wire logic  dog_o,
  output logic      supervise_hold_n = 1'b1,
  output logic      rail_fault_in = 1'b0,
  output wire logic dog_line
);
  // ****************************************************************
  // Host and supplies
  // ****************************************************************
  // The host lowers hold before it lets a rail leave its window.
  always @(posedge core_clk)
    supervise_hold_n <= !hold_req;
  always @(posedge core_clk)
    rail_fault_in <= rail_bad;
  // A pull-up holds the line high unless the device sinks it.
  assign dog_line = dog_oe_n ? 1'b1 : dog_o;
endmodule

//--- testbench/gpfoc_tb_top.sv
// Register and pin sequences for the configuration block.
// Assumes the checker is bound and the far-side model sits beside the top.
`timescale 1ns/10ps
module gpfoc_tb_top;
  import gpfoc_pkg::*;
  // ****************************************************************
  // Signals and tasks
  // ****************************************************************
  localparam logic [7:0] EXP0 [4] = '{8'h11, 8'h22, 8'h33, 8'h11};
  localparam logic [7:0] EXP11 [4] = '{8'h00, 8'h55, 8'h44, 8'h00};
  logic                       core_clk = 1'b0;
  logic                       nrst = 1'b0;
  logic                       clk_en = 1'b1;
  gpfoc_bus_t                 bus = '0;
  logic                       trim_raise_select = 1'b0;
  logic                       trim_lower_select = 1'b0;
  logic                       manual_rst_n = 1'b1;
  logic                       kick_pin = 1'b0;
  logic                       alarm_one_in = 1'b0;
  logic                       alarm_two_in = 1'b0;
  logic                       reset_req_in = 1'b0;
  logic                       dog_expired_in = 1'b0;
  logic                       hold_req = 1'b0;
  logic                       rail_bad = 1'b0;
  logic                       supervise_hold_n, rail_fault_in, dog_line, alarm_out_one;
  logic                       alarm_out_two, alarm_any, reset_out_n, fault_log_req;
  logic                       kick_input, dog_timeout_out, dog_timeout_oe_n;
  logic [7:0]                 rdata;
  logic [NUM_TRIM-1:0][7:0]   trim_level_out;
  logic [NUM_TRIM-1:0]        dac_switch_closed;
  gpfoc_drv_t [NUM_ENOUT-1:0] enout_drv;
  int                         err_count = 0;
  int                         comparisons = 0;
  always #50 core_clk = ~core_clk;
  gpfoc_top dut (.core_clk, .nrst, .clk_en, .bus, .rdata, .trim_raise_select,
    .trim_lower_select, .supervise_hold_n, .manual_rst_n, .kick_pin, .rail_fault_in,
    .alarm_one_in, .alarm_two_in, .reset_req_in, .dog_expired_in, .trim_level_out,
    .dac_switch_closed, .alarm_out_one, .alarm_out_two, .alarm_any, .reset_out_n,
    .fault_log_req, .kick_input, .dog_timeout_out, .dog_timeout_oe_n, .enout_drv);
  gpfoc_partner u_far (.core_clk, .hold_req, .rail_bad, .dog_oe_n(dog_timeout_oe_n),
    .dog_o(dog_timeout_out), .supervise_hold_n, .rail_fault_in, .dog_line);
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1;
    chk("rdata", rdata, e);
  endtask
  function automatic gpfoc_drv_t exp_drv(input int i, input logic [2:0] c);
    if (i >= 6)
      return gpfoc_drv_t'({1'b0, c[1:0]});
    if (c > CFG_CPUMP || (c == CFG_TRACK && i >= 4))
      return DRV_RSVD;
    return gpfoc_drv_t'(c);
  endfunction
  task automatic end_sim();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [2:0] c;
    int         n;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    rd(RST_TMO_REG, RST_TMO_RST);
    rd(8'h90, 8'h00);
    // Every code lands on the six three-bit outputs at once, split fields included; outputs 7 to 9 get its low two bits.
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      wr(ENOUT_CFG_FIRST, {c[1:0], c, c});
      wr(ENOUT_CFG_SECOND, {c[0], c, c, c[2]});
      wr(ENOUT_CFG_THIRD, {c[1:0], c[1:0], c[1:0], c[2:1]});
      tick(3);
      for (int i = 0; i < NUM_ENOUT; i++)
        chk("enout_drv", 16'(enout_drv[i]), 16'(exp_drv(i, c)));
      rd(ENOUT_CFG_FIRST, {c[1:0], c, c});
    end
    wr(TRIM_NORM_BASE, 8'h11);
    wr(TRIM_UP_BASE, 8'h22);
    wr(TRIM_DN_BASE, 8'h33);
    wr(TRIM_DN_LAST, 8'h44);
    wr(TRIM_UP_LAST, 8'h55);
    wr(DAC_EN_LO, 8'hff);
    rd(DAC_EN_LO, 8'h00);
    wr(PAGE_CTRL, 8'h01);
    rd(DAC_EN_LO, 8'h00);
    wr(DAC_EN_LO, 8'h05);
    wr(DAC_EN_HI, 8'h08);
    rd(DAC_EN_HI, 8'h08);
    wr(PAGE_CTRL, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      trim_raise_select <= k[1];
      trim_lower_select <= k[0];
      tick(8);
      chk("trim0", trim_level_out[0], EXP0[k]);
      chk("trim11", trim_level_out[11], EXP11[k]);
      chk("switch", dac_switch_closed, (k == 1 || k == 2) ? 12'hfff : 12'h805);
    end
    // A write while the clock enable is low must leave the register untouched.
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(TRIM_NORM_BASE, 8'h99);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(TRIM_NORM_BASE, 8'h11);
    @(posedge core_clk);
    kick_pin <= 1'b1;
    dog_expired_in <= 1'b1;
    wr(PIN_FUNC_A, 8'h70);
    wr(PIN_FUNC_B, 8'h03);
    tick(8);
    chk("kick", kick_input, 1'b1);
    chk("dog_oe_n", dog_timeout_oe_n, 1'b0);
    chk("dog_line", dog_line, 1'b0);
    rd(STATUS_REG, 8'h0d);
    wr(PIN_FUNC_A, 8'hf0);
    tick(3);
    chk("dog_line", dog_line, 1'b1);
    wr(PIN_FUNC_A, 8'h60);
    tick(3);
    chk("kick", kick_input, 1'b0);
    chk("dog_oe_n", dog_timeout_oe_n, 1'b0);
    @(posedge core_clk);
    alarm_one_in <= 1'b1;
    alarm_two_in <= 1'b1;
    hold_req <= 1'b1;
    tick(8);
    @(posedge core_clk);
    rail_bad <= 1'b1;
    reset_req_in <= 1'b1;
    tick(8);
    chk("alarm_any", alarm_any, 1'b0);
    chk("alarm_one", alarm_out_one, 1'b0);
    chk("fault_log", fault_log_req, 1'b0);
    chk("reset_out_n", reset_out_n, 1'b1);
    @(posedge core_clk);
    hold_req <= 1'b0;
    tick(8);
    chk("alarm_two", alarm_out_two, 1'b1);
    chk("fault_log", fault_log_req, 1'b1);
    chk("reset_out_n", reset_out_n, 1'b0);
    wr(HOLD_CTRL, 8'h02);
    tick(3);
    @(posedge core_clk);
    rail_bad <= 1'b0;
    reset_req_in <= 1'b0;
    tick(8);
    chk("alarm_any", alarm_any, 1'b1);
    wr(HOLD_CTRL, 8'h00);
    tick(8);
    chk("alarm_any", alarm_any, 1'b0);
    wr(RST_TMO_REG, 8'h01);
    @(posedge core_clk);
    manual_rst_n <= 1'b0;
    tick(8);
    chk("reset_out_n", reset_out_n, 1'b0);
    @(posedge core_clk);
    manual_rst_n <= 1'b1;
    tick(95);
    chk("reset_out_n", reset_out_n, 1'b0);
    n = 0;
    while (reset_out_n !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    chk("reset_out_n", reset_out_n, 1'b1);
    end_sim();
  end
endmodule
